// *** logic/acldec_pkg.sv ***
package acldec_pkg;

  localparam int ACT_W = 81;
  localparam int MODE_POS = 5;
  localparam int MODE_W = 2;
  localparam int POL_ON_POS = 9;
  localparam int POL_IDX_POS = 10;
  localparam int POL_IDX_W = 9;
  localparam int EXCL_POS = 19;
  localparam int MASK_POS = 20;
  localparam int MASK_W = 11;
  localparam int CMD_POS = 31;
  localparam int CMD_W = 9;
  localparam int SAO_POS = 40;
  localparam int TS_ID_W = 6;
  localparam int MAC_W = 48;
  localparam int MAC_LOW_W = 32;
  localparam int MAC_HIGH_W = 16;
  localparam int MAC_CLR_BIT = 40;

  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_SWAP = 4'h8;
  localparam logic [2:0] CMD_ONE_STEP = 3'h2;
  localparam logic [2:0] CMD_TWO_STEP = 3'h3;
  localparam logic [3:0] CMD_ORIGIN = 4'h9;
  localparam int CMD_ADDSUB_BIT = 7;
  localparam int CMD_EGR_BIT = 5;

  typedef enum logic [1:0] {
    ACLDEC_MASK_NONE = 2'h0,
    ACLDEC_MASK_PERMIT = 2'h1,
    ACLDEC_MASK_POLICY = 2'h2,
    ACLDEC_MASK_REDIRECT = 2'h3
  } acldec_mode_type;

  typedef enum logic [1:0] {
    ACLDEC_DLY_NONE = 2'h0,
    ACLDEC_DLY_ONE = 2'h1,
    ACLDEC_DLY_TWO = 2'h2,
    ACLDEC_DLY_RSVD = 2'h3
  } acldec_dly_type;

  typedef struct packed {
    logic swap_mac;
    logic one_step;
    logic addsub;
    logic add_egress_delay;
    logic [1:0] ingress_dly_sel;
    logic two_step;
    logic [TS_ID_W-1:0] ts_id;
    logic origin;
  } acldec_rew_type;

  localparam logic [MASK_W-1:0] MASK_RST = 11'h000;
  localparam logic [POL_IDX_W-1:0] POL_RST = 9'h000;
  localparam logic [MAC_W-1:0] MAC_RST = 48'h0;
  localparam logic [31:0] DLY_RST = 32'h0;

endpackage

// *** logic/acldec_rew.sv ***
`timescale 1ns/1ps
module acldec_rew
  import acldec_pkg::*;
(
  input wire logic [acldec_pkg::CMD_W-1:0] i_cmd,
  output acldec_pkg::acldec_rew_type o_rew
);
  import acldec_pkg::*;

  always_comb
  begin
    o_rew = '0;
    // Unused command bits assumed zero by the programmer
    o_rew.swap_mac = (i_cmd[3:0] == CMD_SWAP);
    o_rew.one_step = (i_cmd[2:0] == CMD_ONE_STEP);
    o_rew.two_step = (i_cmd[2:0] == CMD_TWO_STEP);
    o_rew.origin = (i_cmd[3:0] == CMD_ORIGIN);
    if (o_rew.one_step)
    begin
      o_rew.addsub = i_cmd[CMD_ADDSUB_BIT];
      o_rew.add_egress_delay = i_cmd[CMD_EGR_BIT];
      o_rew.ingress_dly_sel = i_cmd[4:3];
    end
    if (o_rew.two_step)
    begin
      o_rew.ts_id = i_cmd[8:3];
    end
    if (i_cmd[3:0] == CMD_NOP)
    begin
      o_rew = '0;
    end
  end
endmodule

// *** logic/acldec_top.sv ***
// Notes on behaviour
// - Bits 18:10 select the rule policer used when policing.
// - Bit 19 disables QoS and port policers, leaving rule policer only.
// - Exclusive policing honoured only from second lookup vector.
// - Bits 30:20 form a port mask applied per mask mode.
// - Bits 39:31 are the rewrite command; low nibble zero means no-op.
// - Low nibble 8 swaps MAC addresses and clears new source bit 40.
// - Low three bits 2 adds residence time to correction field.
// - One-step: command bit 7 enables add/subtract mode.
// - One-step: command bit 5 adds egress delay at egress.
// - Low three bits 3 stores departure stamp in egress queue.
// - Bit 40 replaces source MAC with the egress port MAC.
// - Mask mode: none, AND permit, replace lookup, redirect; CPU kept.
// - Bit 9 enables rule policing, first lookup only.
`timescale 1ns/1ps
module acldec_top
  import acldec_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_act_valid,
  input wire logic i_act_second,
  input wire logic [acldec_pkg::ACT_W-1:0] i_action,
  input wire logic [acldec_pkg::MASK_W-1:0] i_dest_set,
  input wire logic [acldec_pkg::MASK_W-1:0] i_lookup_mask,
  input wire logic [acldec_pkg::MASK_W-1:0] i_cpu_port_mask,
  input wire logic i_backplane,
  input wire logic [31:0] i_ingress_delay_one,
  input wire logic [31:0] i_ingress_delay_two,
  input wire logic [acldec_pkg::MAC_LOW_W-1:0] i_port_mac_low,
  input wire logic [acldec_pkg::MAC_HIGH_W-1:0] i_port_mac_high,
  input wire logic [acldec_pkg::MAC_W-1:0] i_frame_dmac,
  input wire logic [acldec_pkg::MAC_W-1:0] i_frame_smac,
  output logic o_valid,
  output logic o_policing_on,
  output logic [acldec_pkg::POL_IDX_W-1:0] o_policer_select,
  output logic o_exclusive_rule_policing,
  output logic [acldec_pkg::MASK_W-1:0] o_fwd_mask,
  output acldec_pkg::acldec_rew_type o_rew,
  output logic [31:0] o_rx_delay_sub,
  output logic o_src_addr_override,
  output logic [acldec_pkg::MAC_W-1:0] o_dmac,
  output logic [acldec_pkg::MAC_W-1:0] o_smac
);
  import acldec_pkg::*;

  logic [CMD_W-1:0] rewrite_command;
  acldec_rew_type rew_dec;
  acldec_mode_type mask_mode;
  logic [MASK_W-1:0] port_mask;

  logic valid_ff, nxt_valid;
  logic pol_on_ff, nxt_pol_on;
  logic [POL_IDX_W-1:0] pol_sel_ff, nxt_pol_sel;
  logic excl_ff, nxt_excl;
  logic [MASK_W-1:0] mask_ff, nxt_mask;
  acldec_rew_type rew_ff, nxt_rew;
  logic [31:0] dly_ff, nxt_dly;
  logic sao_ff, nxt_sao;
  logic [MAC_W-1:0] dmac_ff, nxt_dmac;
  logic [MAC_W-1:0] smac_ff, nxt_smac;

  // All fields sliced from the same vector, no partial state
  assign rewrite_command = i_action[CMD_POS +: CMD_W];
  assign mask_mode = acldec_mode_type'(i_action[MODE_POS +: MODE_W]);
  assign port_mask = i_action[MASK_POS +: MASK_W];

  acldec_rew u_rew
  (
    .i_cmd(rewrite_command),
    .o_rew(rew_dec)
  );

  function automatic logic [MASK_W-1:0] apply_mask(
    input acldec_mode_type mode,
    input logic [MASK_W-1:0] pm,
    input logic [MASK_W-1:0] dst,
    input logic [MASK_W-1:0] lkp,
    input logic [MASK_W-1:0] cpu
  );
    logic [MASK_W-1:0] res;
    res = dst;
    unique case (mode)
      ACLDEC_MASK_NONE: res = dst;
      ACLDEC_MASK_PERMIT: res = dst & pm;
      ACLDEC_MASK_POLICY: res = (dst & ~lkp) | pm;
      ACLDEC_MASK_REDIRECT: res = pm;
    endcase
    // Processor port bits always pass through untouched
    return (res & ~cpu) | (dst & cpu);
  endfunction

  // Policing group, held between vectors
  always_comb
  begin
    nxt_valid = i_act_valid;
    nxt_pol_on = pol_on_ff;
    nxt_pol_sel = pol_sel_ff;
    nxt_excl = excl_ff;
    if (i_act_valid)
    begin
      nxt_pol_on = i_action[POL_ON_POS] & ~i_act_second;
      nxt_pol_sel = i_action[POL_IDX_POS +: POL_IDX_W];
      // Flag from the first lookup has no meaning, so it is dropped
      nxt_excl = i_action[EXCL_POS] & i_act_second;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      valid_ff <= 1'h0;
      pol_on_ff <= 1'h0;
      pol_sel_ff <= POL_RST;
      excl_ff <= 1'h0;
    end
    else
    begin
      valid_ff <= nxt_valid;
      pol_on_ff <= nxt_pol_on;
      pol_sel_ff <= nxt_pol_sel;
      excl_ff <= nxt_excl;
    end
  end

  // Forwarding group
  always_comb
  begin
    nxt_mask = mask_ff;
    if (i_act_valid)
    begin
      nxt_mask = apply_mask(mask_mode, port_mask, i_dest_set,
        i_lookup_mask, i_cpu_port_mask);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      mask_ff <= MASK_RST;
    end
    else
    begin
      mask_ff <= nxt_mask;
    end
  end

  // Rewrite group; delay zero unless one-step asks for one and i_backplane is low
  always_comb
  begin
    nxt_rew = rew_ff;
    nxt_dly = dly_ff;
    if (i_act_valid)
    begin
      nxt_rew = rew_dec;
      nxt_dly = DLY_RST;
      if (rew_dec.one_step && !i_backplane)
      begin
        unique case (acldec_dly_type'(rew_dec.ingress_dly_sel))
          ACLDEC_DLY_ONE: nxt_dly = i_ingress_delay_one;
          ACLDEC_DLY_TWO: nxt_dly = i_ingress_delay_two;
          default: nxt_dly = DLY_RST;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      rew_ff <= '0;
      dly_ff <= DLY_RST;
    end
    else
    begin
      rew_ff <= nxt_rew;
      dly_ff <= nxt_dly;
    end
  end

  // Address group; override comes after swap so it wins
  always_comb
  begin
    nxt_sao = sao_ff;
    nxt_dmac = dmac_ff;
    nxt_smac = smac_ff;
    if (i_act_valid)
    begin
      nxt_sao = i_action[SAO_POS];
      nxt_dmac = i_frame_dmac;
      nxt_smac = i_frame_smac;
      if (rew_dec.swap_mac)
      begin
        nxt_dmac = i_frame_smac;
        nxt_smac = i_frame_dmac;
        nxt_smac[MAC_CLR_BIT] = 1'h0;
      end
      if (i_action[SAO_POS])
      begin
        nxt_smac = {i_port_mac_high, i_port_mac_low};
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      sao_ff <= 1'h0;
      dmac_ff <= MAC_RST;
      smac_ff <= MAC_RST;
    end
    else
    begin
      sao_ff <= nxt_sao;
      dmac_ff <= nxt_dmac;
      smac_ff <= nxt_smac;
    end
  end

  assign o_valid = valid_ff;
  assign o_policing_on = pol_on_ff;
  assign o_policer_select = pol_sel_ff;
  assign o_exclusive_rule_policing = excl_ff;
  assign o_fwd_mask = mask_ff;
  assign o_rew = rew_ff;
  assign o_rx_delay_sub = dly_ff;
  assign o_src_addr_override = sao_ff;
  assign o_dmac = dmac_ff;
  assign o_smac = smac_ff;
endmodule

// *** dv/acldec_checker.sv ***
`timescale 1ns/1ps
module acldec_checker
  import acldec_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_act_valid,
  input wire logic i_act_second,
  input wire logic [acldec_pkg::ACT_W-1:0] i_action,
  input wire logic o_valid,
  input wire logic o_policing_on,
  input wire logic [acldec_pkg::POL_IDX_W-1:0] o_policer_select,
  input wire logic o_exclusive_rule_policing,
  input wire logic [acldec_pkg::MASK_W-1:0] o_fwd_mask,
  input wire acldec_pkg::acldec_rew_type o_rew,
  input wire logic o_src_addr_override
);
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  sequence s_take;
    i_act_valid ##1 o_valid;
  endsequence
  chk_valid_follow: assert property (i_act_valid |-> s_take)
    else $error("valid missing after capture");
  chk_valid_idle: assert property (!i_act_valid |=> !o_valid)
    else $error("valid without capture");
  chk_police_first: assert property (i_act_valid |=>
    o_policing_on == ($past(i_action[9]) && !$past(i_act_second)))
    else $error("policing enable wrong");
  chk_policer_index: assert property (i_act_valid |=>
    o_policer_select == $past(i_action[18:10]))
    else $error("policer index wrong");
  chk_excl_second: assert property (i_act_valid |=>
    o_exclusive_rule_policing == ($past(i_action[19]) && $past(i_act_second)))
    else $error("exclusive policing wrong");
  chk_override_bit: assert property (i_act_valid |=>
    o_src_addr_override == $past(i_action[40]))
    else $error("address override wrong");
  chk_nop_clear: assert property (
    i_act_valid && i_action[34:31] == 4'h0 |=> o_rew == '0)
    else $error("no-op command not clear");
  chk_fields_hold: assert property (!i_act_valid |=>
    $stable(o_fwd_mask) && $stable(o_rew) && $stable(o_policer_select))
    else $error("fields moved while idle");
endmodule
bind acldec_top acldec_checker i_chk (.*);

// *** dv/acldec_far_model.sv ***
`timescale 1ns/1ps
module acldec_far_model
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic [7:0] o_frames
);
  // Rewriter acts only on frames handed over with valid high
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_frames <= 8'h00;
    else if (i_valid)
      o_frames <= o_frames + 8'h01;
  end
endmodule

// *** dv/acldec_top_tb.sv ***
`timescale 1ns/1ps
module acldec_top_tb;
  import acldec_pkg::*;
  logic i_clk_sys, i_rst, i_act_valid, i_act_second, i_backplane, o_valid;
  logic [ACT_W-1:0] i_action;
  logic [MASK_W-1:0] i_dest_set, i_lookup_mask, i_cpu_port_mask, o_fwd_mask;
  logic [31:0] i_ingress_delay_one, i_ingress_delay_two, o_rx_delay_sub;
  logic [31:0] i_port_mac_low;
  logic [15:0] i_port_mac_high;
  logic [47:0] i_frame_dmac, i_frame_smac, o_dmac, o_smac;
  logic o_policing_on, o_exclusive_rule_policing, o_src_addr_override;
  logic [POL_IDX_W-1:0] o_policer_select;
  acldec_rew_type o_rew;
  acldec_rew_type er;
  logic [7:0] frames;
  int failures = 0;
  int n_tests = 0;
  int sent = 0;
  // Undefined command bits kept zero
  logic [8:0] cmds [7] = '{9'h000, 9'h008, 9'h0aa, 9'h012, 9'h002,
    9'h1fb, 9'h009};
  always #2.5 i_clk_sys = ~i_clk_sys;
  acldec_top i_dut (.*);
  acldec_far_model i_far (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_valid(o_valid), .o_frames(frames));
  task automatic check(input string nm, input logic [63:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic send(input logic [80:0] a, input logic sec);
    @(negedge i_clk_sys);
    i_action = a;
    i_act_second = sec;
    i_act_valid = 1'b1;
    @(negedge i_clk_sys);
    i_act_valid = 1'b0;
    sent++;
    check("valid", o_valid, 1'b1);
  endtask
  function automatic logic [80:0] act(logic sao, logic [8:0] cmd,
    logic [10:0] pm, logic ex, logic [8:0] idx, logic pol, logic [1:0] md);
    return {40'h0, sao, cmd, pm, ex, idx, pol, 2'h0, md, 5'h00};
  endfunction
  function automatic logic [10:0] emask(logic [1:0] m, logic [10:0] pm);
    logic [10:0] x;
    x = (m == 2'h0) ? i_dest_set : (m == 2'h1) ? (i_dest_set & pm) :
      (m == 2'h2) ? ((i_dest_set & ~i_lookup_mask) | pm) : pm;
    return (x & ~i_cpu_port_mask) | (i_dest_set & i_cpu_port_mask);
  endfunction
  function automatic acldec_rew_type erew(logic [8:0] c);
    acldec_rew_type r;
    r = '0;
    r.swap_mac = c[3:0] == 4'h8;
    r.one_step = c[2:0] == 3'h2;
    r.addsub = r.one_step & c[7];
    r.add_egress_delay = r.one_step & c[5];
    r.ingress_dly_sel = r.one_step ? c[4:3] : 2'h0;
    r.two_step = c[2:0] == 3'h3;
    r.ts_id = r.two_step ? c[8:3] : 6'h00;
    r.origin = c[3:0] == 4'h9;
    return r;
  endfunction
  function automatic logic [31:0] edly(logic [8:0] c);
    if (c[2:0] != 3'h2 || c[4:3] == 2'h0 || c[4:3] == 2'h3)
      return 32'h0;
    return c[3] ? i_ingress_delay_one : i_ingress_delay_two;
  endfunction
  initial
  begin
    i_clk_sys = 1'h0;
    i_rst = 1'h1;
    i_act_valid = 1'h0;
    i_act_second = 1'h0;
    i_action = '0;
    i_backplane = 1'h0;
    i_dest_set = 11'h5a3;
    i_lookup_mask = 11'h0f0;
    i_cpu_port_mask = 11'h401;
    i_ingress_delay_one = 32'h0001_2345;
    i_ingress_delay_two = 32'h0006_789a;
    i_port_mac_low = 32'hc0de_0001;
    i_port_mac_high = 16'h0a0b;
    i_frame_dmac = 48'h0300_0000_0011;
    i_frame_smac = 48'h0a00_0000_0022;
    repeat (6) @(negedge i_clk_sys);
    i_rst = 0;
    for (int s = 0; s < 2; s++)
    begin
      send(act(0, 9'h0, 11'h0, 1, 9'h1a5, 1, 2'h0), s[0]);
      check("pol_on", o_policing_on, !s[0]);
      check("pol_idx", o_policer_select, 9'h1a5);
      check("excl", o_exclusive_rule_policing, s[0]);
    end
    $display("test policing done");
    for (int m = 0; m < 4; m++)
    begin
      send(act(0, 9'h0, 11'h3c5, 0, 9'h0, 0, m[1:0]), 0);
      check("fwd_mask", o_fwd_mask, emask(m[1:0], 11'h3c5));
    end
    repeat (2) @(negedge i_clk_sys);
    check("idle_valid", o_valid, 1'b0);
    check("mask_hold", o_fwd_mask, emask(2'h3, 11'h3c5));
    $display("test port mask done");
    foreach (cmds[k])
    begin
      send(act(0, cmds[k], 11'h0, 0, 9'h0, 0, 2'h0), 1);
      er = erew(cmds[k]);
      check("rew", o_rew, er);
      check("rew_ts", o_rew[7:0], er[7:0]);
      check("rx_dly", o_rx_delay_sub, edly(cmds[k]));
    end
    i_backplane = 1;
    send(act(0, 9'h00a, 11'h0, 0, 9'h0, 0, 2'h0), 1);
    check("bp_dly", o_rx_delay_sub, 32'h0);
    i_backplane = 0;
    $display("test rewrite command done");
    for (int o = 0; o < 2; o++)
    begin
      send(act(o[0], 9'h008, 11'h0, 0, 9'h0, 0, 2'h0), 1);
      check("dmac", o_dmac, i_frame_smac);
      check("smac", o_smac, o ? {i_port_mac_high, i_port_mac_low} :
        (i_frame_dmac & ~(48'h1 << 40)));
      check("sao", o_src_addr_override, o[0]);
    end
    // Model counts one edge after the pulse shows
    @(negedge i_clk_sys);
    check("frames", frames, sent[7:0]);
    $display("test address rewrite done");
    give_verdict;
  end
  initial
  begin
    #100000;
    failures++;
    give_verdict;
  end
endmodule
